// ===== common/epl_defines.svh
`ifndef EPL_DEFINES_SVH
`define EPL_DEFINES_SVH
// ==========================================
// Octet positions inside the parameter block
`define EPL_OCT_LEN 8'd1
`define EPL_OCT_TYPE 8'd2
`define EPL_OCT_SLOT 8'd3
`define EPL_OCT_RSV 8'd4
`define EPL_OCT_FLAGS 8'd5
`define EPL_OCT_SOL 8'd14
`define EPL_OCT_UNIT 8'd15
// ==========================================
// Header values
`define EPL_LEN_SHORT 8'h15
`define EPL_LEN_LONG 8'h29
`define EPL_BLK_TYPE 8'h81
`define EPL_BLK_SLOT 8'h02
// ==========================================
// Flag bit positions in the flag octet
`define EPL_FB_CLASS4 1
`define EPL_FB_PRE_ONE 2
`define EPL_FB_SCALE 3
`define EPL_FB_ALARM 4
`define EPL_FB_COMPAT 5
// ==========================================
// Resolution and range limits
`define EPL_ST_RES 32'h0000_4000
`define EPL_MIN_RES 32'h0000_0002
`define EPL_DEF_TMR 64'h0000_0000_0400_0000
`define EPL_UNIT_MAX 8'h03
`define EPL_CTL_MASTER_BIT 10
// ==========================================
// Profile versions, BCD
`define EPL_PROF_OLD 8'h31
`define EPL_PROF_NEW 8'h41
// ==========================================
// Register offsets and reset values
`define EPL_REG_CTRL 8'h00
`define EPL_REG_STATUS 8'h04
`define EPL_REG_UNITS_PER_REVOLUTION 8'h08
`define EPL_REG_TMR_LO 8'h0C
`define EPL_REG_TMR_HI 8'h10
`define EPL_REG_POS_ONE 8'h14
`define EPL_REG_POS_WIDE 8'h18
`define EPL_REG_COUNTS 8'h1C
`define EPL_RST_SOL 8'h01
`endif

// ===== common/epl_pkg.sv
package epl_pkg;
    // ==========================================
    // Loader phases
    typedef enum logic [1:0] {
        EPL_IDLE = 2'b00,
        EPL_COLLECT = 2'b01,
        EPL_EVAL = 2'b10
    } epl_phase_t;

    // Raw octets of one block
    typedef struct packed {
        logic [7:0] len;
        logic [7:0] btype;
        logic [7:0] slot;
        logic [7:0] rsv;
        logic [7:0] flags;
        logic [31:0] units_per_revolution;
        logic [31:0] tmr;
        logic [7:0] sol;
        logic [7:0] unit;
        logic [31:0] units_per_revolution_hi;
        logic [31:0] units_per_revolution_lo;
        logic [31:0] tmr_hi;
        logic [31:0] tmr_lo;
    } epl_raw_t;

    // Applied configuration
    typedef struct packed {
        logic class4;
        logic pre_one;
        logic scale;
        logic alarm;
        logic compat;
        logic [7:0] sol;
        logic [1:0] unit;
        logic [31:0] units_per_revolution;
        logic [63:0] tmr;
    } epl_cfg_t;

    // Loader state
    typedef struct packed {
        epl_phase_t phase;
        logic [7:0] idx;
        epl_raw_t raw;
        epl_cfg_t cfg;
        logic dir_ccw;
        logic [7:0] sol_param;
        logic res_vld;
        logic res_ok;
        logic [7:0] ok_cnt;
        logic [7:0] rej_cnt;
        logic [31:0] rdata;
        logic p_ack;
        logic p_nak;
        logic [7:0] sol_lim;
        logic ctl_req;
        logic [7:0] prof;
        logic short_diag;
    } epl_state_t;

    // Position counter state
    typedef struct packed {
        logic [13:0] acc;
        logic [63:0] one;
        logic [63:0] wide;
    } epl_pos_t;
endpackage : epl_pkg

// ===== rtl/epl_pos.sv
`timescale 1ns/1ps
`include "epl_defines.svh"
module epl_pos
    import epl_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Motion and scaling
    input wire logic i_step,
    input wire logic i_up,
    input wire logic [14:0] i_units_per_revolution,
    input wire logic [63:0] i_tmr,
    // Preset
    input wire logic i_preset,
    input wire logic i_preset_one,
    input wire logic [63:0] i_preset_val,
    // Positions
    output logic [63:0] o_pos_one,
    output logic [63:0] o_pos_wide
);
    epl_pos_t st, nxt;
    logic [14:0] sum;
    logic unit;

    // Wrapping step by one unit
    function automatic logic [63:0] step_pos(logic [63:0] p, logic up, logic [63:0] tmr);
        if (up) begin
            step_pos = (p + 64'd1 >= tmr) ? 64'd0 : p + 64'd1;
        end else begin
            step_pos = (p == 64'd0) ? tmr - 64'd1 : p - 64'd1;
        end
    endfunction : step_pos

    // Fraction accumulator gives units_per_revolution units per turn
    always_comb begin
        nxt = st;
        sum = {1'b0, st.acc} + i_units_per_revolution;
        unit = sum[14];
        if (i_step) begin
            nxt.acc = sum[13:0];
            if (unit) begin
                nxt.one = step_pos(st.one, i_up, i_tmr);
                nxt.wide = step_pos(st.wide, i_up, i_tmr);
            end
        end
        if (i_preset && i_preset_val < i_tmr) begin
            nxt.wide = i_preset_val;
            if (i_preset_one) begin
                nxt.one = i_preset_val;
            end
        end
    end

    // State register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= nxt;
        end
    end

    assign o_pos_one = st.one;
    assign o_pos_wide = st.wide;

    // ==========================================
    // Checks
    a_wrap_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        i_step && unit && i_up && !i_preset && st.wide + 64'd1 >= i_tmr |=> st.wide == 64'd0)
        else $error("wide position did not wrap to zero");
    a_step_dir: assert property (@(posedge i_clk) disable iff (i_rst)
        i_step && unit && !i_up && !i_preset && st.wide != 64'd0 |=> st.wide == $past(st.wide) - 64'd1)
        else $error("down step did not decrement");
endmodule : epl_pos

// ===== rtl/epl_loader.sv
// Overview of operation
// - Octet one holds block length, only 21 or 41 accepted.
// - Octet two holds block type, always 129.
// - Octet three holds slot number, always 2.
// - Fields sit at listed octet plus block start offset.
// - Class-four flag gates preset; cleared flag refuses every preset.
// - Class four off: clockwise counts up, default scaling.
// - Preset hits values two and three; flag decides value one.
// - Scaling flag only acts while class four is on.
// - Alarm flag clear in compatibility mode gives short diagnosis only.
// - Outside compatibility, control words act only with master bit set.
// - Control-requested status bit is zero in compatibility, one otherwise.
// - Profile version is old in compatibility mode, new otherwise.
// - Sign-of-life limit from block only in compatibility mode.
// - Octet fifteen selects one of four speed units.
// - Units per turn between two and physical singleturn resolution.
// - Position advances by units per turn each shaft turn.
// - Total range up to 64-bit; singleturn needs it equal to units per turn.
// - 64-bit parameters rebuilt from upper and lower 32-bit halves.
// - Reject when 64 and 32 bit forms differ nonzero or both zero.
// - Counting direction selectable, clockwise or counter-clockwise.
// - Position wraps to zero past the total range.
`timescale 1ns/1ps
`include "epl_defines.svh"
module epl_loader
    import epl_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Parameter octet stream
    input wire logic i_prm_start,
    input wire logic i_oct_vld,
    input wire logic [7:0] i_oct_data,
    input wire logic [7:0] i_blk_offset,
    input wire logic i_singleturn,
    // Cyclic control
    input wire logic [15:0] i_ctl_word_two,
    input wire logic i_preset_req,
    input wire logic [63:0] i_preset_val,
    input wire logic i_step,
    input wire logic i_step_cw,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Results and mode outputs
    output logic o_result_vld,
    output logic o_result_ok,
    output logic o_preset_ack,
    output logic o_preset_nak,
    output logic o_ctl_requested,
    output logic [7:0] o_profile_ver,
    output logic o_short_diag,
    output logic [7:0] o_sol_limit,
    output logic [1:0] o_speed_unit,
    output logic [31:0] o_pos_one,
    output logic [31:0] o_pos_two,
    output logic [63:0] o_pos_wide
);
    epl_state_t st, nxt;
    logic [7:0] rel;
    logic chk_ok;
    epl_cfg_t new_cfg;
    logic do_preset;
    logic scale_on;
    logic [14:0] units_per_revolution_eff;
    logic [63:0] tmr_eff;
    logic [63:0] pos_one, pos_wide;
    logic [31:0] rd_val;

    // ==========================================
    // Helpers

    // Shift one octet into a big-endian word
    function automatic logic [31:0] sh32(logic [31:0] v, logic [7:0] d);
        sh32 = {v[23:0], d};
    endfunction : sh32

    // Inconsistent split between 32-bit and 64-bit forms
    function automatic logic bad_split(logic [31:0] a, logic [63:0] b);
        bad_split = (a != 32'd0 && b != 64'd0 && {32'd0, a} != b) || (a == 32'd0 && b == 64'd0);
    endfunction : bad_split

    // Pick the nonzero of the two forms
    function automatic logic [63:0] pick(logic [31:0] a, logic [63:0] b);
        pick = (a != 32'd0) ? {32'd0, a} : b;
    endfunction : pick

    // ==========================================
    // Block check and decoded configuration
    logic long_blk;
    logic [63:0] mupr64, tmr64, units_per_revolution_v, tmr_v;
    always_comb begin
        long_blk = st.raw.len == `EPL_LEN_LONG;
        mupr64 = long_blk ? {st.raw.units_per_revolution_hi, st.raw.units_per_revolution_lo} : 64'd0;
        tmr64 = long_blk ? {st.raw.tmr_hi, st.raw.tmr_lo} : 64'd0;
        units_per_revolution_v = pick(st.raw.units_per_revolution, mupr64);
        tmr_v = pick(st.raw.tmr, tmr64);
        new_cfg.class4 = st.raw.flags[`EPL_FB_CLASS4];
        new_cfg.pre_one = st.raw.flags[`EPL_FB_PRE_ONE];
        new_cfg.scale = st.raw.flags[`EPL_FB_SCALE];
        new_cfg.alarm = st.raw.flags[`EPL_FB_ALARM];
        new_cfg.compat = st.raw.flags[`EPL_FB_COMPAT];
        new_cfg.sol = st.raw.sol;
        new_cfg.unit = st.raw.unit[1:0];
        new_cfg.units_per_revolution = units_per_revolution_v[31:0];
        new_cfg.tmr = tmr_v;
        chk_ok = (long_blk || st.raw.len == `EPL_LEN_SHORT)
            && st.raw.btype == `EPL_BLK_TYPE
            && st.raw.slot == `EPL_BLK_SLOT
            && !bad_split(st.raw.units_per_revolution, mupr64)
            && !bad_split(st.raw.tmr, tmr64)
            && units_per_revolution_v >= {32'd0, `EPL_MIN_RES}
            && units_per_revolution_v <= {32'd0, `EPL_ST_RES}
            && tmr_v >= {32'd0, `EPL_MIN_RES}
            && (!i_singleturn || tmr_v == units_per_revolution_v)
            && st.raw.unit <= `EPL_UNIT_MAX
            && (!new_cfg.compat || st.raw.sol != 8'h00);
    end

    // ==========================================
    // Motion steering
    always_comb begin
        scale_on = st.cfg.class4 && st.cfg.scale;
        units_per_revolution_eff = scale_on ? st.cfg.units_per_revolution[14:0] : 15'(`EPL_ST_RES);
        tmr_eff = scale_on ? st.cfg.tmr : `EPL_DEF_TMR;
        do_preset = i_preset_req && st.cfg.class4
            && (st.cfg.compat || i_ctl_word_two[`EPL_CTL_MASTER_BIT]);
    end

    // Register read mux
    always_comb begin
        case (i_addr)
            `EPL_REG_CTRL: rd_val = {16'd0, st.sol_param, 7'd0, st.dir_ccw};
            `EPL_REG_STATUS: rd_val = {16'd0, 1'b0, st.cfg.unit, st.cfg.compat, st.cfg.alarm,
                st.cfg.scale, st.cfg.pre_one, st.cfg.class4, 6'd0, st.phase != EPL_IDLE, st.res_ok};
            `EPL_REG_UNITS_PER_REVOLUTION: rd_val = st.cfg.units_per_revolution;
            `EPL_REG_TMR_LO: rd_val = st.cfg.tmr[31:0];
            `EPL_REG_TMR_HI: rd_val = st.cfg.tmr[63:32];
            `EPL_REG_POS_ONE: rd_val = pos_one[31:0];
            `EPL_REG_POS_WIDE: rd_val = pos_wide[31:0];
            `EPL_REG_COUNTS: rd_val = {16'd0, st.rej_cnt, st.ok_cnt};
            default: rd_val = 32'd0;
        endcase
    end

    // ==========================================
    // Next state
    always_comb begin
        nxt = st;
        nxt.res_vld = 1'b0;
        nxt.p_ack = do_preset;
        nxt.p_nak = i_preset_req && !do_preset;
        rel = 8'(st.idx + 8'd1 - i_blk_offset);
        if (i_wr && i_addr == `EPL_REG_CTRL) begin
            nxt.dir_ccw = i_wdata[0];
            nxt.sol_param = i_wdata[15:8];
        end
        if (i_rd) begin
            nxt.rdata = rd_val;
        end
        case (st.phase)
            EPL_IDLE: begin
            end
            EPL_COLLECT: begin
                if (i_oct_vld) begin
                    nxt.idx = st.idx + 8'd1;
                    if (st.idx >= i_blk_offset) begin
                        if (rel == `EPL_OCT_LEN) nxt.raw.len = i_oct_data;
                        if (rel == `EPL_OCT_TYPE) nxt.raw.btype = i_oct_data;
                        if (rel == `EPL_OCT_SLOT) nxt.raw.slot = i_oct_data;
                        if (rel == `EPL_OCT_RSV) nxt.raw.rsv = i_oct_data;
                        if (rel == `EPL_OCT_FLAGS) nxt.raw.flags = i_oct_data;
                        if (rel inside {[8'd6:8'd9]}) nxt.raw.units_per_revolution = sh32(st.raw.units_per_revolution, i_oct_data);
                        if (rel inside {[8'd10:8'd13]}) nxt.raw.tmr = sh32(st.raw.tmr, i_oct_data);
                        if (rel == `EPL_OCT_SOL) nxt.raw.sol = i_oct_data;
                        if (rel == `EPL_OCT_UNIT) nxt.raw.unit = i_oct_data;
                        if (rel inside {[8'd22:8'd25]}) nxt.raw.units_per_revolution_hi = sh32(st.raw.units_per_revolution_hi, i_oct_data);
                        if (rel inside {[8'd26:8'd29]}) nxt.raw.units_per_revolution_lo = sh32(st.raw.units_per_revolution_lo, i_oct_data);
                        if (rel inside {[8'd30:8'd33]}) nxt.raw.tmr_hi = sh32(st.raw.tmr_hi, i_oct_data);
                        if (rel inside {[8'd34:8'd37]}) nxt.raw.tmr_lo = sh32(st.raw.tmr_lo, i_oct_data);
                        if (rel == `EPL_LEN_LONG || (rel == `EPL_LEN_SHORT && st.raw.len != `EPL_LEN_LONG)) begin
                            nxt.phase = EPL_EVAL;
                        end
                    end
                end
            end
            EPL_EVAL: begin
                nxt.res_vld = 1'b1;
                nxt.res_ok = chk_ok;
                nxt.phase = EPL_IDLE;
                if (chk_ok) begin
                    nxt.cfg = new_cfg;
                    nxt.ok_cnt = st.ok_cnt + 8'd1;
                end else begin
                    nxt.rej_cnt = st.rej_cnt + 8'd1;
                end
            end
            default: begin
                nxt.phase = EPL_IDLE;
            end
        endcase
        if (i_prm_start && st.phase != EPL_EVAL) begin
            nxt.phase = EPL_COLLECT;
            nxt.idx = 8'd0;
            nxt.raw = '0;
        end
        // Mode dependent outputs
        nxt.sol_lim = st.cfg.compat ? st.cfg.sol : st.sol_param;
        nxt.ctl_req = !st.cfg.compat;
        nxt.prof = st.cfg.compat ? `EPL_PROF_OLD : `EPL_PROF_NEW;
        nxt.short_diag = st.cfg.compat && !st.cfg.alarm;
    end

    // State register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
            st.sol_param <= `EPL_RST_SOL;
            st.sol_lim <= `EPL_RST_SOL;
            st.ctl_req <= 1'b1;
            st.prof <= `EPL_PROF_NEW;
            st.cfg.units_per_revolution <= `EPL_ST_RES;
            st.cfg.tmr <= `EPL_DEF_TMR;
        end else begin
            st <= nxt;
        end
    end

    // ==========================================
    // Position counter
    epl_pos u_pos (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_step(i_step),
        .i_up(st.cfg.class4 ? (i_step_cw ^ st.dir_ccw) : i_step_cw),
        .i_units_per_revolution(units_per_revolution_eff),
        .i_tmr(tmr_eff),
        .i_preset(do_preset),
        .i_preset_one(st.cfg.pre_one),
        .i_preset_val(i_preset_val),
        .o_pos_one(pos_one),
        .o_pos_wide(pos_wide)
    );

    // Outputs from flops
    assign o_rdata = st.rdata;
    assign o_result_vld = st.res_vld;
    assign o_result_ok = st.res_ok;
    assign o_preset_ack = st.p_ack;
    assign o_preset_nak = st.p_nak;
    assign o_ctl_requested = st.ctl_req;
    assign o_profile_ver = st.prof;
    assign o_short_diag = st.short_diag;
    assign o_sol_limit = st.sol_lim;
    assign o_speed_unit = st.cfg.unit;
    assign o_pos_one = pos_one[31:0];
    assign o_pos_two = pos_wide[31:0];
    assign o_pos_wide = pos_wide;

    // ==========================================
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_rejected;
        ##1 st.res_vld && !st.res_ok;
    endsequence
    sequence s_evaluating;
        st.phase == EPL_EVAL;
    endsequence

    a_result_once: assert property (st.res_vld |=> !st.res_vld)
        else $error("result pulse longer than one cycle");
    a_reject_keep: assert property (s_evaluating and !chk_ok |=> st.cfg == $past(st.cfg))
        else $error("rejected block changed settings");
    a_len_check: assert property (s_evaluating and st.raw.len != `EPL_LEN_SHORT
        && st.raw.len != `EPL_LEN_LONG |-> s_rejected)
        else $error("bad length accepted");
    a_type_check: assert property (s_evaluating and st.raw.btype != `EPL_BLK_TYPE |-> s_rejected)
        else $error("bad block type accepted");
    a_slot_check: assert property (s_evaluating and st.raw.slot != `EPL_BLK_SLOT |-> s_rejected)
        else $error("bad slot accepted");
    a_split_check: assert property (s_evaluating and long_blk && st.raw.units_per_revolution != 32'd0
        && {st.raw.units_per_revolution_hi, st.raw.units_per_revolution_lo} != 64'd0 && st.raw.units_per_revolution_lo != st.raw.units_per_revolution |-> s_rejected)
        else $error("inconsistent split accepted");
    a_units_per_revolution_range: assert property (s_evaluating and st.raw.len == `EPL_LEN_SHORT
        && st.raw.units_per_revolution < `EPL_MIN_RES |-> s_rejected)
        else $error("too small units per turn accepted");
    a_type_offset: assert property (st.phase == EPL_COLLECT && i_oct_vld && !i_prm_start
        && st.idx == 8'(i_blk_offset + 8'd1) |=> st.raw.btype == $past(i_oct_data))
        else $error("type octet not taken at offset");
    a_preset_gate: assert property (i_preset_req && !st.cfg.class4 |=> o_preset_nak && !o_preset_ack)
        else $error("preset not refused with class four off");
    a_master_bit: assert property (i_preset_req && st.cfg.class4 && !st.cfg.compat
        && !i_ctl_word_two[`EPL_CTL_MASTER_BIT] |=> o_preset_nak)
        else $error("preset taken without master control");
    a_ctl_mode: assert property (1 |=> o_ctl_requested == !$past(st.cfg.compat))
        else $error("control requested bit wrong for mode");
    a_prof_mode: assert property (1 |=> o_profile_ver == ($past(st.cfg.compat) ? `EPL_PROF_OLD : `EPL_PROF_NEW))
        else $error("profile version wrong for mode");
    a_diag_mode: assert property (!st.cfg.compat |=> !o_short_diag)
        else $error("short diagnosis outside compatibility");
    a_sol_mode: assert property (st.cfg.compat |=> o_sol_limit == $past(st.cfg.sol))
        else $error("sign-of-life limit not from block");
endmodule : epl_loader

// ===== bench/epl_master_model.sv
`timescale 1ns/1ps
module epl_master_model (
    // Clock, reset and command
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_go,
    input wire logic i_slow,
    input wire logic [7:0] i_offset,
    input wire logic [7:0] i_count,
    input wire logic [327:0] i_blk,
    // Octet stream
    output logic o_prm_start,
    output logic o_oct_vld,
    output logic [7:0] o_oct_data,
    output logic o_busy
);
    logic [7:0] idx_ff;
    logic gap_ff;
    // ==========================================
    // Telegram sender; idle data toggles so no stale octet lingers
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            {o_prm_start, o_oct_vld, o_busy, gap_ff} <= 4'h0;
            o_oct_data <= 8'h00;
            idx_ff <= 8'h00;
        end else begin
            o_prm_start <= i_go;
            o_oct_vld <= 1'b0;
            o_oct_data <= ~o_oct_data;
            gap_ff <= i_slow & ~gap_ff;
            if (i_go) begin
                o_busy <= 1'b1;
                idx_ff <= 8'h00;
            end else if (o_busy && !gap_ff) begin
                o_oct_vld <= 1'b1;
                // Foreign blocks first, then ours
                if (idx_ff < i_offset) o_oct_data <= 8'h5A ^ idx_ff;
                else o_oct_data <= i_blk[(40 - int'(idx_ff - i_offset)) * 8 +: 8];
                idx_ff <= idx_ff + 8'h01;
                o_busy <= (idx_ff != i_offset + i_count - 8'h01);
            end
        end
    end
endmodule : epl_master_model

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    // ==========================================
    // Signals, notes and counters
    logic clk = 1'b0, rst = 1'b1, go = 1'b0, slow = 1'b0, st = 1'b0, preq = 1'b0, step = 1'b0, cw = 1'b0;
    logic wr = 1'b0, rd = 1'b0, rdd = 1'b0, ps, ov, busy, rv, rok, ack, nak, creq, sd;
    logic [7:0] off = 8'h00, cnt = 8'h15, addr = 8'h00, od, prof, sol;
    logic [15:0] ctl = 16'h0000;
    logic [31:0] wd = 32'h0000_0000, rdat, p1, p2, v, ep, seed = 32'h0001_6660;
    logic [63:0] pv = 64'h0, pw;
    logic [327:0] blk = '0;
    logic [1:0] unit;
    logic [63:0] rq[$], aq[$], pq[$];
    logic [23:0] hd[4] = '{24'h16_8102, 24'h15_8002, 24'h15_8103, 24'h15_8102};
    logic [31:0] mt[4] = '{32'h1, 32'h2, 32'h4000, 32'h4001};
    int bad_count = 0, checked = 0, nres = 0;

    always #12.5 clk = ~clk;

    epl_master_model i_master (.i_clk(clk), .i_rst(rst), .i_go(go), .i_slow(slow), .i_offset(off),
        .i_count(cnt), .i_blk(blk), .o_prm_start(ps), .o_oct_vld(ov), .o_oct_data(od), .o_busy(busy));

    epl_loader i_dut (.i_clk(clk), .i_rst(rst), .i_prm_start(ps), .i_oct_vld(ov), .i_oct_data(od),
        .i_blk_offset(off), .i_singleturn(st), .i_ctl_word_two(ctl), .i_preset_req(preq),
        .i_preset_val(pv), .i_step(step), .i_step_cw(cw), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdat), .o_result_vld(rv), .o_result_ok(rok), .o_preset_ack(ack),
        .o_preset_nak(nak), .o_ctl_requested(creq), .o_profile_ver(prof), .o_short_diag(sd),
        .o_sol_limit(sol), .o_speed_unit(unit), .o_pos_one(p1), .o_pos_two(p2), .o_pos_wide(pw));

    // ==========================================
    // Watchers: oldest note against each answer
    always @(posedge clk) rdd <= rd;
    always @(negedge clk) begin
        if (rv) begin
            chk(rok, rq.pop_front());
            nres++;
        end
        if (ack | nak) chk({ack, nak}, pq.pop_front());
        if (rdd) chk(rdat, aq.pop_front());
    end

    // ==========================================
    // Helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic logic [327:0] mk(input logic [7:0] ln, input logic [15:0] hr, input logic [7:0] fl,
        input logic [31:0] mu, input logic [31:0] tm, input logic [7:0] sl, input logic [7:0] un,
        input logic [63:0] m6, input logic [63:0] t6);
        return {ln, hr, 8'h00, fl, mu, tm, sl, un, 48'h0, m6, t6, 32'h0};
    endfunction : mk
    function automatic logic [327:0] sb(input logic [7:0] fl, input logic [31:0] mu, input logic [31:0] tm,
        input logic [7:0] sl, input logic [7:0] un);
        return mk(8'h15, 16'h8102, fl, mu, tm, sl, un, 64'h0, 64'h0);
    endfunction : sb
    function automatic logic [327:0] lb(input logic [31:0] mu, input logic [31:0] tm, input logic [63:0] m6,
        input logic [63:0] t6);
        return mk(8'h29, 16'h8102, 8'h00, mu, tm, 8'h01, 8'h00, m6, t6);
    endfunction : lb
    task chk(input logic [63:0] s, input logic [63:0] e);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task wrr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wrr
    task rdr(input logic [7:0] a, input logic [63:0] e);
        aq.push_back(e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask : rdr
    task send(input logic [327:0] b, input logic e);
        int n;
        n = nres;
        rq.push_back(e);
        @(posedge clk);
        go <= 1'b1;
        blk <= b;
        cnt <= (b[327:320] === 8'h29) ? 8'h29 : 8'h15;
        @(posedge clk);
        go <= 1'b0;
        for (int i = 0; i < 400 && nres == n; i++) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask : send
    task pre(input logic [31:0] pval, input logic [1:0] e);
        pq.push_back(e);
        @(posedge clk);
        preq <= 1'b1;
        pv <= {32'h0, pval};
        @(posedge clk);
        preq <= 1'b0;
        @(posedge clk);
    endtask : pre
    task stp(input logic d);
        @(posedge clk);
        step <= 1'b1;
        cw <= d;
        @(posedge clk);
        step <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : stp
    task end_sim();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim

    // ==========================================
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_sim();
    end

    // ==========================================
    // Scenarios
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({creq, prof, sol, rv}, {1'b1, 8'h41, 8'h01, 1'b0});
        rdr(8'h08, 64'h4000);
        rdr(8'h0C, 64'h0400_0000);
        rdr(8'h40, 64'h0);
        $display("test reset done");
        for (int i = 0; i < 4; i++) send(mk(hd[i][23:16], hd[i][15:0], 8'h00, 32'h4000, 32'h4000, 8'h01, 8'h00,
            64'h0, 64'h0), i == 3);
        for (int u = 0; u < 5; u++) begin
            send(sb(8'h00, 32'h4000, 32'h4000, 8'h01, u[7:0]), u < 4);
            chk(unit, (u < 4) ? u : 3);
        end
        $display("test header done");
        foreach (mt[i]) send(sb(8'h00, mt[i], 32'h0001_0000, 8'h01, 8'h00), i == 1 || i == 2);
        rdr(8'h08, 64'h4000);
        st <= 1'b1;
        send(sb(8'h00, 32'h0100, 32'h0200, 8'h01, 8'h00), 1'b0);
        send(sb(8'h00, 32'h0100, 32'h0100, 8'h01, 8'h00), 1'b1);
        st <= 1'b0;
        off <= 8'h0B;
        slow <= 1'b1;
        send(lb(32'h4000, 32'h0001_0000, 64'h4000, 64'h0001_0000), 1'b1);
        send(lb(32'h4000, 32'h0001_0000, 64'h0001_0000_4000, 64'h0001_0000), 1'b0);
        send(lb(32'h0, 32'h0001_0000, 64'h0, 64'h0001_0000), 1'b0);
        send(lb(32'h0, 32'h0, 64'h3000, 64'h0000_0001_0000_0000), 1'b1);
        rdr(8'h08, 64'h3000);
        rdr(8'h10, 64'h1);
        rdr(8'h0C, 64'h0);
        off <= 8'h00;
        slow <= 1'b0;
        $display("test ranges done");
        send(sb(8'h22, 32'h4000, 32'h4000, 8'h07, 8'h00), 1'b1);
        chk({creq, prof, sd, sol}, {1'b0, 8'h31, 1'b1, 8'h07});
        v = xs() & 32'h03FF_FFFF;
        pre(v, 2'b10);
        chk({p1, pw[31:0]}, {32'h0, v});
        send(sb(8'h32, 32'h4000, 32'h4000, 8'h07, 8'h00), 1'b1);
        chk(sd, 1'b0);
        send(sb(8'h02, 32'h4000, 32'h4000, 8'h07, 8'h00), 1'b1);
        chk({creq, prof, sd}, {1'b1, 8'h41, 1'b0});
        wrr(8'h00, 32'h5500);
        rdr(8'h00, 64'h5500);
        chk(sol, 8'h55);
        pre(v, 2'b01);
        ctl <= 16'h0400;
        v = xs() & 32'h03FF_FFFF;
        pre(v, 2'b10);
        chk({p1, pw[31:0]}, {32'h0, v});
        send(sb(8'h06, 32'h4000, 32'h4000, 8'h01, 8'h00), 1'b1);
        ep = xs() & 32'h03FF_FFFF;
        pre(ep, 2'b10);
        chk({p1, pw[31:0]}, {ep, ep});
        $display("test modes done");
        send(sb(8'h00, 32'h4000, 32'h4000, 8'h01, 8'h00), 1'b1);
        pre(v, 2'b01);
        repeat (3) stp(1'b1);
        chk(p1, ep + 32'h3);
        send(sb(8'h0E, 32'h4000, 32'h4000, 8'h01, 8'h00), 1'b1);
        pre(32'h3FFF, 2'b10);
        stp(1'b1);
        chk(p1, 32'h0);
        wrr(8'h00, 32'h5501);
        stp(1'b1);
        chk({p1, p2}, {32'h3FFF, 32'h3FFF});
        chk(pw, 64'h3FFF);
        $display("test motion done");
        end_sim();
    end
endmodule : testbench
